// ==== logic/dss_cfg.svh ====
// Constants for the dual supply supervisor: clock rate, oscillator
// dividers, tick counts, select encodings and register map.
// Assumes a 50 MHz system clock and a 32-bit AXI4-Lite register bus.
`ifndef DSS_CFG_SVH
`define DSS_CFG_SVH
`define DSS_CLK_HZ    50000000
`define DSS_F_LO_HZ   200000
`define DSS_F_HI_HZ   300000
`define DSS_DIV_LO    (`DSS_CLK_HZ / `DSS_F_LO_HZ)
`define DSS_DIV_HI    (`DSS_CLK_HZ / `DSS_F_HI_HZ)
`define DSS_PG_TICKS  32000
`define DSS_UV_TICKS  6144
`define DSS_SS_TICKS  512
`define DSS_SS_STEPS  5
`define DSS_ORD_GND   2'h0
`define DSS_ORD_REF   2'h1
`define DSS_ORD_VL    2'h2
`define DSS_A_CTRL    32'h0000_0000
`define DSS_A_STATUS  32'h0000_0004
`define DSS_A_SOFT    32'h0000_0008
`define DSS_A_PGCNT   32'h0000_000c
`define DSS_CTRL_RST  2'h3
`define DSS_RESP_OK   2'h0
`define DSS_RESP_DEC  2'h3
`endif

// ==== logic/dss_pkg.sv ====
// Types shared by the dual supply supervisor and its bench.
// Assumes dss_cfg.svh supplies the numeric constants.
package dss_pkg;
  typedef enum logic [1:0] {
    DSS_SHUT = 2'b00,
    DSS_STBY = 2'b01,
    DSS_RUN  = 2'b10
  } dss_mode_e;

  // Digital outcome of one rail's analog comparators
  typedef struct packed {
    logic in_reg;
    logic under;
    logic over;
    logic ilim;
  } dss_rail_s;

  typedef struct packed {
    logic [1:0] order_select;
    logic       shutdown_request_low;
    logic       master_or_low_rail_enable;
    logic       timing_or_high_rail_enable;
    logic       fixed_freq;
    logic       osc_sync;
    logic       internal_logic_supply;
    logic       battery_low;
  } dss_ctl_s;

  typedef struct packed {
    logic ov_protect_en;
    logic uv_protect_en;
  } dss_ctrl_s;

  typedef struct packed {
    logic [2:0] step_hi;
    logic [2:0] step_lo;
    logic       power_good;
    logic       ov_fault;
    logic       uv_fault;
    logic [1:0] low_side_drive;
    logic [1:0] rail_en;
    dss_mode_e  mode;
  } dss_status_s;
endpackage : dss_pkg

// ==== logic/dss_supervisor.sv ====
// Supervisory logic for a two-rail switching regulator controller.
// Assumes comparator results and control pins arrive as plain levels
// and are resynchronised here; one 50 MHz clock, AXI4-Lite registers.
//
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "dss_cfg.svh"

// Operation
// R1: Power-good low until outputs regulate
// R2: Power-good after 32000 oscillator ticks
// R3: Independent enables monitor only lower rail
// R4: Undervoltage check armed 6144 ticks after enable
// R5: Undervoltage latches both rails off, clamped
// R6: Faults clear on shutdown, enable, battery
// R7: Overvoltage latches both low-side drives high
// R8: Low-side drive high when rail disabled; here only outside shutdown or with the logic supply
// R9: Shutdown turns every block off
// R10: Reference select gives independent rail enables
// R11: Grounded select enables higher rail first
// R12: Logic-supply select enables lower rail first
// R13: Fixed frequency disables minimum-current comparator
// R14: Fixed frequency sets reverse limit negative
// R15: Frequency may stretch under overload, dropout
// R16: Soft-start counters cleared when rail off
// R17: Current limit steps five times to 512
// R18: Independent soft-start logic per rail
// R19: Sync selects rate; falling edge restarts cycle
// R20: Current-limit trip turns high side off
// R21: All inputs synchronised before use
// R22: Power-good restarts on regulation loss, fault
module dss_supervisor #(
  parameter int PG_TICKS = `DSS_PG_TICKS, // Power-good delay in ticks
  parameter int UV_TICKS = `DSS_UV_TICKS  // Undervoltage arm delay
) (
  input  wire logic                     ref_clk_in,        // Clock
  input  wire logic                     srst_in,           // Sync reset
  input  wire dss_pkg::dss_ctl_s        ctl_in,            // Pins
  input  wire dss_pkg::dss_rail_s [1:0] rails_in,          // Comparators
  output logic [1:0]                    rail_en_out,       // Rail on
  output logic [1:0]                    low_side_drive_out,// Rectifier
  output logic [1:0]                    high_side_off_out, // Latch reset
  output logic [5:0]                    ilim_step_out,     // Hi, lo step
  output logic                          power_good_out,    // Power good
  output logic                          min_comp_off_out,  // No min comp
  output logic                          rev_limit_neg_out, // -100 mV
  output logic                          osc_tick_out,      // Osc pulse
  input  wire logic [31:0]              s_axi_awaddr,      // AW addr
  input  wire logic                     s_axi_awvalid,     // AW valid
  output logic                          s_axi_awready,     // AW ready
  input  wire logic [31:0]              s_axi_wdata,       // W data
  input  wire logic [3:0]               s_axi_wstrb,       // W strobes
  input  wire logic                     s_axi_wvalid,      // W valid
  output logic                          s_axi_wready,      // W ready
  output logic [1:0]                    s_axi_bresp,       // B resp
  output logic                          s_axi_bvalid,      // B valid
  input  wire logic                     s_axi_bready,      // B ready
  input  wire logic [31:0]              s_axi_araddr,      // AR addr
  input  wire logic                     s_axi_arvalid,     // AR valid
  output logic                          s_axi_arready,     // AR ready
  output logic [31:0]                   s_axi_rdata,       // R data
  output logic [1:0]                    s_axi_rresp,       // R resp
  output logic                          s_axi_rvalid,      // R valid
  input  wire logic                     s_axi_rready       // R ready
);
  import dss_pkg::*;

  localparam int         LO        = 0;
  localparam int         HI        = 1;
  localparam logic [14:0] PG_N     = 15'(PG_TICKS);
  localparam logic [12:0] UV_N     = 13'(UV_TICKS);
  localparam logic [9:0]  SS_N     = 10'(`DSS_SS_TICKS);
  localparam logic [2:0]  STEP_MAX = 3'(`DSS_SS_STEPS);
  localparam logic [7:0]  DIV_LO   = 8'(`DSS_DIV_LO - 1);
  localparam logic [7:0]  DIV_HI   = 8'(`DSS_DIV_HI - 1);

  // Limit reference steps in fifths of full scale
  function automatic logic [2:0] dss_ss_step(input logic [9:0] cnt);
    logic [12:0] prod;
    prod = 13'(cnt) * 13'(`DSS_SS_STEPS);
    if (cnt >= SS_N) begin
      dss_ss_step = STEP_MAX;
    end else begin
      dss_ss_step = 3'(prod / 13'(`DSS_SS_TICKS));
    end
  endfunction : dss_ss_step

  dss_ctl_s           ctl_meta_reg;
  dss_ctl_s           ctl_q;
  dss_rail_s [1:0]    rail_meta_reg;
  dss_rail_s [1:0]    rail_q;
  logic               sync_d_reg;
  logic               sync_fall;
  logic [7:0]         div_reg;
  logic               tick_reg;
  dss_mode_e          mode_reg;
  dss_mode_e          mode_next;
  logic [1:0]         req_en;
  logic [1:0]         rail_en_reg;
  logic [1:0]         dl_reg;
  logic [1:0]         hs_off_reg;
  logic [1:0]         under_v;
  logic [1:0]         over_v;
  logic [1:0]         uv_armed;
  logic [12:0]        uv_cnt_reg [2];
  logic [9:0]         ss_cnt_reg [2];
  logic [2:0]         step_reg [2];
  logic               uv_set;
  logic               ov_set;
  logic               fault_clr;
  logic               uv_fault_reg;
  logic               ov_fault_reg;
  logic               indep;
  logic               mon_ok;
  logic [14:0]        pg_cnt_reg;
  logic               pg_reg;
  logic               min_off_reg;
  logic               rev_neg_reg;
  dss_ctrl_s          ctrl_reg;
  dss_status_s        status;
  logic               aw_hold_reg;
  logic               w_hold_reg;
  logic [31:0]        awaddr_reg;
  logic [31:0]        wdata_reg;
  logic [3:0]         wstrb_reg;
  logic               aw_fire;
  logic               w_fire;
  logic               wr_go;
  logic [31:0]        wr_addr;
  logic [31:0]        wr_data;
  logic [3:0]         wr_strb;
  logic               wr_hit;
  logic               bvalid_reg;
  logic [1:0]         bresp_reg;
  logic               rvalid_reg;
  logic [1:0]         rresp_reg;
  logic [31:0]        rdata_reg;
  logic [31:0]        rd_mux;
  logic [1:0]         rd_resp;

  // Two-stage resynchronisers; the first stage feeds nothing else
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      ctl_meta_reg  <= '0;
      ctl_q         <= '0;
      rail_meta_reg <= '0;
      rail_q        <= '0;
    end else begin
      ctl_meta_reg  <= ctl_in;        // R21
      ctl_q         <= ctl_meta_reg;  // R21
      rail_meta_reg <= rails_in;      // R21
      rail_q        <= rail_meta_reg; // R21
    end
  end

  // Oscillator tick; an external falling edge restarts the period
  assign sync_fall = sync_d_reg & ~ctl_q.osc_sync; // R19

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      sync_d_reg <= 1'b0;
      div_reg    <= '0;
      tick_reg   <= 1'b0;
    end else begin
      sync_d_reg <= ctl_q.osc_sync;
      if (sync_fall || div_reg == '0) begin
        div_reg  <= ctl_q.osc_sync ? DIV_HI : DIV_LO; // R19
        tick_reg <= 1'b1;
      end else begin
        div_reg  <= div_reg - 8'h01;
        tick_reg <= 1'b0;
      end
    end
  end

  // Mode decode; in the grounded and logic-supply orders the second rail waits for the first and the timing pin
  always_comb begin
    mode_next = DSS_STBY;
    req_en    = 2'b00;
    if (!ctl_q.shutdown_request_low) begin
      mode_next = DSS_SHUT; // R9
    end else begin
      case (ctl_q.order_select)
        `DSS_ORD_REF: begin
          req_en[LO] = ctl_q.master_or_low_rail_enable; // R10
          req_en[HI] = ctl_q.timing_or_high_rail_enable; // R10
        end
        `DSS_ORD_GND: begin
          if (ctl_q.master_or_low_rail_enable) begin
            req_en[HI] = 1'b1; // R11
            req_en[LO] = ctl_q.timing_or_high_rail_enable
                         & rail_en_reg[HI]; // R11
          end
        end
        `DSS_ORD_VL: begin
          if (ctl_q.master_or_low_rail_enable) begin
            req_en[LO] = 1'b1; // R12
            req_en[HI] = ctl_q.timing_or_high_rail_enable
                         & rail_en_reg[LO]; // R12
          end
        end
        default: begin
          req_en = 2'b00;
        end
      endcase
      if (|req_en) begin
        mode_next = DSS_RUN;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      mode_reg <= DSS_SHUT;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // Fault latches; a new event outranks a clear in the same cycle
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      under_v[i]  = rail_q[i].under;
      over_v[i]   = rail_q[i].over;
      uv_armed[i] = (uv_cnt_reg[i] == UV_N);
    end
  end

  assign uv_set    = ctrl_reg.uv_protect_en & |(uv_armed & under_v); // R5
  assign ov_set    = ctrl_reg.ov_protect_en & |over_v; // R7
  assign fault_clr = ~ctl_q.shutdown_request_low
                     | ~ctl_q.master_or_low_rail_enable
                     | ctl_q.battery_low; // R6

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      uv_fault_reg <= 1'b0;
      ov_fault_reg <= 1'b0;
    end else begin
      uv_fault_reg <= uv_set | (uv_fault_reg & ~fault_clr); // R5 R6
      ov_fault_reg <= ov_set | (ov_fault_reg & ~fault_clr); // R7 R6
    end
  end

  // Rail enables and drivers
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      rail_en_reg <= 2'b00;
      dl_reg      <= 2'b00;
      hs_off_reg  <= 2'b11;
    end else begin
      for (int i = 0; i < 2; i++) begin
        rail_en_reg[i] <= req_en[i] & ~uv_fault_reg
                          & ~ov_fault_reg; // R5 R9
        // In shutdown without the logic supply only a latched fault can hold the gate high
        dl_reg[i] <= uv_fault_reg | ov_fault_reg // R5 R7
                     | (~rail_en_reg[i]
                        & ((mode_reg != DSS_SHUT)
                           | ctl_q.internal_logic_supply)); // R8
        hs_off_reg[i] <= ~rail_en_reg[i] | rail_q[i].ilim; // R20
      end
    end
  end

  // Per-rail arm timers and soft-start counters
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      for (int i = 0; i < 2; i++) begin
        uv_cnt_reg[i] <= '0;
        ss_cnt_reg[i] <= '0;
        step_reg[i]   <= '0;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin // R18
        if (!rail_en_reg[i]) begin
          uv_cnt_reg[i] <= '0; // R4
          ss_cnt_reg[i] <= '0; // R16
        end else if (tick_reg) begin
          if (uv_cnt_reg[i] != UV_N) begin
            uv_cnt_reg[i] <= uv_cnt_reg[i] + 13'h0001; // R4
          end
          if (ss_cnt_reg[i] != SS_N) begin
            ss_cnt_reg[i] <= ss_cnt_reg[i] + 10'h001; // R17
          end
        end
        step_reg[i] <= dss_ss_step(ss_cnt_reg[i]); // R17
      end
    end
  end

  // Power-good monitor
  assign indep  = (ctl_q.order_select == `DSS_ORD_REF);
  assign mon_ok = (mode_reg == DSS_RUN) & ~uv_fault_reg & ~ov_fault_reg
                  & rail_en_reg[LO] & rail_q[LO].in_reg
                  & (indep | (rail_en_reg[HI]
                              & rail_q[HI].in_reg)); // R1 R3

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      pg_cnt_reg <= '0;
      pg_reg     <= 1'b0;
    end else begin
      if (!mon_ok) begin
        pg_cnt_reg <= '0; // R22
      end else if (tick_reg && pg_cnt_reg != PG_N) begin
        pg_cnt_reg <= pg_cnt_reg + 15'h0001; // R2
      end
      pg_reg <= mon_ok & (pg_cnt_reg == PG_N); // R1 R2 R22
    end
  end

  // Overload and dropout stretching stay with the analog PWM loop
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      min_off_reg <= 1'b0;
      rev_neg_reg <= 1'b0;
    end else begin
      min_off_reg <= ctl_q.fixed_freq; // R13 R15
      rev_neg_reg <= ctl_q.fixed_freq; // R14
    end
  end

  // AXI4-Lite write path; address and data accepted in either order
  assign s_axi_awready = ~aw_hold_reg & ~bvalid_reg;
  assign s_axi_wready  = ~w_hold_reg & ~bvalid_reg;
  assign aw_fire = s_axi_awvalid & s_axi_awready;
  assign w_fire  = s_axi_wvalid & s_axi_wready;
  assign wr_addr = aw_hold_reg ? awaddr_reg : s_axi_awaddr;
  assign wr_data = w_hold_reg ? wdata_reg : s_axi_wdata;
  assign wr_strb = w_hold_reg ? wstrb_reg : s_axi_wstrb;
  assign wr_go   = (aw_hold_reg | aw_fire) & (w_hold_reg | w_fire)
                   & ~bvalid_reg;
  assign wr_hit  = (wr_addr == `DSS_A_CTRL) | (wr_addr == `DSS_A_STATUS)
                   | (wr_addr == `DSS_A_SOFT) | (wr_addr == `DSS_A_PGCNT);

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= '0;
      wstrb_reg   <= '0;
    end else if (wr_go) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
    end else begin
      if (aw_fire) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_hold_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `DSS_RESP_OK;
    end else if (wr_go) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_hit ? `DSS_RESP_OK : `DSS_RESP_DEC;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Protection enables; clearing one also disarms its latch source
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      ctrl_reg <= dss_ctrl_s'(`DSS_CTRL_RST);
    end else if (wr_go && wr_addr == `DSS_A_CTRL && wr_strb[0]) begin
      ctrl_reg <= dss_ctrl_s'(wr_data[$bits(dss_ctrl_s)-1:0]);
    end
  end

  // Read path
  always_comb begin
    status.step_hi        = step_reg[HI];
    status.step_lo        = step_reg[LO];
    status.power_good     = pg_reg;
    status.ov_fault       = ov_fault_reg;
    status.uv_fault       = uv_fault_reg;
    status.low_side_drive = dl_reg;
    status.rail_en        = rail_en_reg;
    status.mode           = mode_reg;
    rd_resp               = `DSS_RESP_OK;
    case (s_axi_araddr)
      `DSS_A_CTRL:   rd_mux = 32'(ctrl_reg);
      `DSS_A_STATUS: rd_mux = 32'(status);
      `DSS_A_SOFT:   rd_mux = {6'h00, ss_cnt_reg[HI],
                               6'h00, ss_cnt_reg[LO]};
      `DSS_A_PGCNT:  rd_mux = 32'(pg_cnt_reg);
      default: begin
        rd_mux  = '0;
        rd_resp = `DSS_RESP_DEC;
      end
    endcase
  end

  assign s_axi_arready = ~rvalid_reg;

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= `DSS_RESP_OK;
    end else if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_mux;
      rresp_reg  <= rd_resp;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid       = bvalid_reg;
  assign s_axi_bresp        = bresp_reg;
  assign s_axi_rvalid       = rvalid_reg;
  assign s_axi_rdata        = rdata_reg;
  assign s_axi_rresp        = rresp_reg;
  assign rail_en_out        = rail_en_reg;
  assign low_side_drive_out = dl_reg;
  assign high_side_off_out  = hs_off_reg;
  assign ilim_step_out      = {step_reg[HI], step_reg[LO]};
  assign power_good_out     = pg_reg;
  assign min_comp_off_out   = min_off_reg;
  assign rev_limit_neg_out  = rev_neg_reg;
  assign osc_tick_out       = tick_reg;

  default clocking dss_cb @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);

  property p_pg_cause;
    power_good_out |-> $past(mon_ok) && $past(pg_cnt_reg) == PG_N;
  endproperty
  a_pg_cause: assert property (p_pg_cause) // R2
    else $error("power good without full delay");

  property p_pg_drop;
    !mon_ok |=> !power_good_out;
  endproperty
  a_pg_drop: assert property (p_pg_drop) // R22
    else $error("power good held after loss of regulation");

  property p_pg_low_rail;
    power_good_out |-> $past(rail_q[LO].in_reg);
  endproperty
  a_pg_low_rail: assert property (p_pg_low_rail) // R1
    else $error("power good while lower rail out of regulation");

  property p_uv_armed;
    $rose(uv_fault_reg) |-> $past(|uv_armed);
  endproperty
  a_uv_armed: assert property (p_uv_armed) // R4
    else $error("undervoltage latched before arm delay");

  property p_uv_off;
    uv_fault_reg |=> rail_en_out == 2'b00 && low_side_drive_out == 2'b11;
  endproperty
  a_uv_off: assert property (p_uv_off) // R5
    else $error("undervoltage did not clamp both rails");

  property p_fault_clear;
    $fell(uv_fault_reg) || $fell(ov_fault_reg) |-> $past(fault_clr);
  endproperty
  a_fault_clear: assert property (p_fault_clear) // R6
    else $error("fault latch cleared without a clear event");

  property p_ov_dl;
    ov_fault_reg |=> low_side_drive_out == 2'b11;
  endproperty
  a_ov_dl: assert property (p_ov_dl) // R7
    else $error("overvoltage did not force rectifiers on");

  property p_dl_disabled;
    !rail_en_out[LO] && ctl_q.internal_logic_supply
      |=> low_side_drive_out[LO];
  endproperty
  a_dl_disabled: assert property (p_dl_disabled) // R8
    else $error("low-side drive low on a disabled rail");

  property p_shutdown;
    !ctl_q.shutdown_request_low ##1 !ctl_q.shutdown_request_low
      |=> rail_en_out == 2'b00 && !power_good_out;
  endproperty
  a_shutdown: assert property (p_shutdown) // R9
    else $error("rails active in shutdown");

  property p_fixed;
    ctl_q.fixed_freq |=> min_comp_off_out && rev_limit_neg_out;
  endproperty
  a_fixed: assert property (p_fixed) // R13
    else $error("fixed frequency select not applied");

  property p_ss_clear;
    !rail_en_out[HI] [*2] |-> ss_cnt_reg[HI] == '0 ##1 ss_cnt_reg[HI] == '0;
  endproperty
  a_ss_clear: assert property (p_ss_clear) // R16
    else $error("soft-start count not cleared on disabled rail");

  property p_ss_full;
    ss_cnt_reg[LO] == SS_N |=> ilim_step_out[2:0] == STEP_MAX;
  endproperty
  a_ss_full: assert property (p_ss_full) // R17
    else $error("current-limit step not full at end of soft start");

  property p_hs_off;
    rail_q[HI].ilim |=> high_side_off_out[HI];
  endproperty
  a_hs_off: assert property (p_hs_off) // R20
    else $error("current-limit trip ignored");

  c_pg_rise:  cover property ($rose(power_good_out));
  c_uv_trip:  cover property ($rose(uv_fault_reg));
  c_ov_trip:  cover property ($rose(ov_fault_reg));
  c_sync_cyc: cover property (sync_fall ##1 tick_reg);
endmodule : dss_supervisor

// ==== test/dss_rail_model.sv ====
// Behavioural comparators of the two power stages.
// Assumes the bench forces under and over faults per rail.
`timescale 1ns/10ps
module dss_rail_model (
  input  wire logic                ref_clk_in, // Clock
  input  wire logic [1:0]          en_in,      // Rail enables
  input  wire logic [1:0]          under_in,   // Force under 70%
  input  wire logic [1:0]          over_in,    // Force over +7%
  output dss_pkg::dss_rail_s [1:0] rails_out   // Comparator levels
);
  import dss_pkg::*;
  logic [7:0] rise_reg [2];

  // Output needs 255 clocks to regulate, so power good cannot be prompt
  always_ff @(posedge ref_clk_in) begin
    for (int i = 0; i < 2; i++) begin
      if (en_in[i] !== 1'b1) begin
        rise_reg[i] <= 8'h00;
      end else if (rise_reg[i] != 8'hff) begin
        rise_reg[i] <= rise_reg[i] + 8'h01;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      rails_out[i].in_reg = rise_reg[i] == 8'hff && !under_in[i];
      rails_out[i].under = under_in[i];
      rails_out[i].over = over_in[i];
      // Inrush trips the limit early in each start
      rails_out[i].ilim = en_in[i] && rise_reg[i] < 8'h10;
    end
  end
endmodule : dss_rail_model

// ==== test/dual_supply_supervisor_test.sv ====
// Bench: modes, power good, faults, fixed frequency, oscillator, regs.
// Assumes dss_rail_model in place of the power stages.
`timescale 1ns/10ps
`include "dss_cfg.svh"
module dual_supply_supervisor_test;
  import dss_pkg::*;
  localparam int PGT = 8;
  logic ref_clk_in = 0;
  logic srst_in = 1;
  dss_ctl_s ctl_in;
  dss_rail_s [1:0] rails_in;
  logic [1:0] rail_en_out, low_side_drive_out, high_side_off_out;
  logic [1:0] und, ovr, s_axi_bresp, s_axi_rresp;
  logic [5:0] ilim_step_out;
  logic power_good_out, min_comp_off_out, rev_limit_neg_out, osc_tick_out;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, q;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  int fails = 0;
  int total_checks = 0;
  int n;
  // Order, shutdown_n, master, timing, then expected rail enables
  logic [6:0] rows [12] = '{7'h2c, 7'h30, 7'h39, 7'h36, 7'h3f, 7'h14,
                            7'h1a, 7'h1f, 7'h30, 7'h59, 7'h5f, 7'h7c};

  dss_supervisor #(.PG_TICKS(PGT), .UV_TICKS(4)) u_dss_supervisor (.*);
  dss_rail_model u_dss_rail_model (.ref_clk_in(ref_clk_in),
    .en_in(rail_en_out), .under_in(und), .over_in(ovr),
    .rails_out(rails_in));

  always #10 ref_clk_in = ~ref_clk_in;

  task automatic chk(input string nm, input logic [31:0] e, s);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  task automatic axi(input logic wr, input logic [31:0] a, d,
                     input logic [1:0] er);
    logic aw, w, ar, dn;
    int k;
    {aw, w, ar, dn} = {wr, wr, !wr, 1'b0};
    @(posedge ref_clk_in);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
    {s_axi_bready, s_axi_rready} <= {wr, !wr};
    for (k = 0; k < 40 && !dn; k++) begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= {aw, w, ar};
      @(negedge ref_clk_in);
      aw = aw & !s_axi_awready;
      w = w & !s_axi_wready;
      ar = ar & !s_axi_arready;
      dn = wr ? s_axi_bvalid : s_axi_rvalid;
      q = s_axi_rdata;
      if (dn) chk("resp", er, wr ? s_axi_bresp : s_axi_rresp);
      @(posedge ref_clk_in);
    end
    {s_axi_bready, s_axi_rready} <= 2'b00;
    if (!dn) begin
      fails++;
      finish_test();
    end
  endtask : axi

  // Pins, then forced faults (under on lower, over on higher rail)
  task automatic set_pins(input logic [4:0] v, input logic [1:0] f,
                          input int w);
    @(posedge ref_clk_in);
    {ctl_in.order_select, ctl_in.shutdown_request_low,
     ctl_in.master_or_low_rail_enable,
     ctl_in.timing_or_high_rail_enable} <= v;
    {und, ovr} <= {1'b0, f[0], f[1], 1'b0};
    repeat (w) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
  endtask : set_pins

  task automatic period(output int p);
    for (p = 0; p < 600 && osc_tick_out !== 1'b1; p++) @(negedge ref_clk_in);
    for (p = 1; p < 600; p++) begin
      @(negedge ref_clk_in);
      if (osc_tick_out === 1'b1) break;
    end
    if (p == 600) begin
      fails++;
      finish_test();
    end
  endtask : period

  initial begin
    ctl_in = 9'h002;
    {und, ovr, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {s_axi_bready, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    repeat (6) @(posedge ref_clk_in);
    srst_in <= 1'b0;
    @(negedge ref_clk_in);
    chk("pg_reset", 0, power_good_out);
    axi(0, `DSS_A_CTRL, 0, `DSS_RESP_OK);
    chk("ctrl_reset", `DSS_CTRL_RST, q);
    axi(1, `DSS_A_CTRL, 0, `DSS_RESP_OK);
    axi(0, `DSS_A_CTRL, 0, `DSS_RESP_OK);
    chk("ctrl_write", 0, q);
    axi(1, `DSS_A_CTRL, `DSS_CTRL_RST, `DSS_RESP_OK);
    axi(1, 32'h10, 1, `DSS_RESP_DEC);
    axi(0, 32'h10, 0, `DSS_RESP_DEC);
    chk("unmapped", 0, q);
    $display("test registers done");
    foreach (rows[i]) begin
      set_pins(rows[i][6:2], 2'b00, 8);
      chk("rail_en", rows[i][1:0], rail_en_out);
      chk("low_side", 2'(~rows[i][1:0]), low_side_drive_out);
    end
    $display("test modes done");
    set_pins(5'h0e, 2'b00, 0);
    for (n = 0; n < 4000 && power_good_out !== 1'b1; n++) @(negedge ref_clk_in);
    if (n == 4000) begin
      fails++;
      finish_test();
    end
    chk("pg_delay", 1, n > PGT * 250 && n < PGT * 250 + 300);
    chk("hs_off", 2'b10, high_side_off_out);
    $display("test power good done");
    // First limit step needs 103 ticks from enable, about 94 still to go
    for (n = 0; n < 30000 && ilim_step_out !== 6'h01; n++)
      @(negedge ref_clk_in);
    chk("ss_step", 1, n > 22500 && n < 24000);
    set_pins(5'h0e, 2'b01, 8);
    chk("pg_drop", 0, power_good_out);
    chk("uv_en", 0, rail_en_out);
    chk("uv_clamp", 3, low_side_drive_out);
    chk("steps", 0, ilim_step_out);
    set_pins(5'h0e, 2'b00, 8);
    chk("uv_latch", 0, rail_en_out);
    axi(0, `DSS_A_STATUS, 0, `DSS_RESP_OK);
    chk("uv_flag", 1, q[6]);
    set_pins(5'h0c, 2'b00, 8);
    set_pins(5'h0e, 2'b00, 8);
    chk("uv_clear", 1, rail_en_out);
    set_pins(5'h0e, 2'b10, 8);
    chk("ov_drive", 3, low_side_drive_out);
    set_pins(5'h0e, 2'b00, 8);
    chk("ov_latch", 3, low_side_drive_out);
    set_pins(5'h0a, 2'b00, 8);
    set_pins(5'h0e, 2'b00, 8);
    chk("ov_clear", 2'b10, low_side_drive_out);
    $display("test faults done");
    for (int v = 1; v >= 0; v--) begin
      @(posedge ref_clk_in);
      ctl_in.fixed_freq <= 1'(v);
      repeat (8) @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      chk("min_comp", v, min_comp_off_out);
      chk("rev_limit", v, rev_limit_neg_out);
    end
    $display("test fixed frequency done");
    for (int s = 0; s < 2; s++) begin
      @(posedge ref_clk_in);
      ctl_in.osc_sync <= 1'(s);
      period(n);
      period(n);
      chk("period", s ? `DSS_DIV_HI : `DSS_DIV_LO, n);
    end
    repeat (50) @(posedge ref_clk_in);
    ctl_in.osc_sync <= 1'b0;
    for (n = 0; n < 600 && osc_tick_out !== 1'b1; n++) @(negedge ref_clk_in);
    chk("sync_edge", 1, n < 6);
    $display("test oscillator done");
    finish_test();
  end
endmodule : dual_supply_supervisor_test
